// ==== shared/pit_pkg.sv ====
package pit_pkg;

  // register bus geometry
  localparam int         ADDR_W        = 4;
  localparam int         DATA_W        = 8;

  // register offsets
  localparam logic [3:0] ADR_RUN       = 4'h0;
  localparam logic [3:0] ADR_MODE      = 4'h1;
  localparam logic [3:0] ADR_CLK       = 4'h2;
  localparam logic [3:0] ADR_TFFC      = 4'h3;
  // compare values live at 4..7, counters read back at 8..b (low two bits pick the timer)
  localparam logic [1:0] PAGE_CMP      = 2'h1;
  localparam logic [1:0] PAGE_CNT      = 2'h2;

  // field positions
  localparam int         RUN_PRESC_BIT = 5;
  localparam int         MODE_PWM_LSB  = 0;
  localparam int         MODE_PA_LSB   = 2;
  localparam int         MODE_PB_BIT   = 6;
  localparam int         TFFC_SRC_BIT  = 0;
  localparam int         TFFC_EN_BIT   = 1;
  localparam int         TFFC_CMD_LSB  = 2;

  // reset values
  localparam logic [7:0] RUN_RST       = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [7:0] CLK_RST       = 8'h00;
  localparam logic [7:0] CMP_RST       = 8'h00;
  localparam logic [7:0] CNT_RST       = 8'h00;
  localparam logic [7:0] PRE_RST       = 8'h00;
  localparam logic [7:0] RD_RST        = 8'h00;
  localparam logic       TOG_RST       = 1'b0;
  localparam logic       TEN_RST       = 1'b0;
  localparam logic       TSRC_RST      = 1'b0;
  localparam logic       ARM_RST       = 1'b1;

  // pair mode select codes
  localparam logic [1:0] PM_8BIT       = 2'b00;
  localparam logic [1:0] PM_16BIT      = 2'b01;
  localparam logic [1:0] PM_PPG        = 2'b10;
  localparam logic [1:0] PM_PWM        = 2'b11;

  // toggle command codes
  localparam logic [1:0] CMD_CLR       = 2'b00;
  localparam logic [1:0] CMD_SET       = 2'b01;
  localparam logic [1:0] CMD_INV       = 2'b10;
  localparam logic [1:0] CMD_KEEP      = 2'b11;

  // clock source codes
  localparam logic [1:0] CK_CASC       = 2'b00;
  localparam logic [1:0] CK_T1         = 2'b01;
  localparam logic [1:0] CK_T16        = 2'b10;
  localparam logic [1:0] CK_T256       = 2'b11;

  // pwm period codes and overflow limits
  localparam logic [1:0] PW_N6         = 2'b01;
  localparam logic [1:0] PW_N7         = 2'b10;
  localparam logic [7:0] PWM_LIM6      = 8'h3f;
  localparam logic [7:0] PWM_LIM7      = 8'h7f;
  localparam logic [7:0] PWM_LIM8      = 8'hff;

  // prescaler tap points, in system clocks: every 1, 16 and 256 cycles
  localparam logic [3:0] PRE_T16_END   = 4'hf;
  localparam logic [7:0] PRE_T256_END  = 8'hff;

endpackage

// ==== logic/pit_counter.sv ====
`timescale 1ns/1ps
module pit_counter
  import pit_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic       inc_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] cmp_i,
  input  wire logic       cmp_en_i,
  output logic      [7:0] count_o,
  output logic            match_o,
  output logic            ovf_o
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] count_inc;

  ////////////////////////////////////////////////////////////////////////
  // compare looks at the value the counter is about to take, so a compare
  // of 00 fires exactly on the wrap from ff
  assign count_inc = count_reg + 8'h01;
  assign match_o   = run_i & inc_i & cmp_en_i & (count_inc == cmp_i);
  assign ovf_o     = run_i & inc_i & (count_reg == 8'hff);

  // stop clears; the pair logic decides when a match clears
  assign count_next = !run_i ? CNT_RST :
                      clr_i  ? CNT_RST :
                      inc_i  ? count_inc : count_reg;

  ////////////////////////////////////////////////////////////////////////
  // up-counter storage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_reg <= CNT_RST;
    else
      count_reg <= count_next;
  end

  assign count_o = count_reg;

endmodule

// ==== logic/pit_timer_pair.sv ====
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - command 1,0 inverts the output toggle at once, timers running or not
// - command 0,0 clears the toggle, 0,1 sets it, whatever the timers do
// - pair mode 0,1 cascades low and high timers into one 16-bit timer
// - in 16-bit mode high counts low overflows; low keeps its own tap
// - second pair cascades the same way but has no toggle output
// - in 16-bit mode, writing low compare halts comparison until high compare is written
// - 16-bit low match raises low interrupt but does not clear the counter
// - 16-bit full match clears both counters, raises high irq, may invert
// - in 16-bit mode the timers move the toggle only on the full 16-bit match
// - cascaded 8-bit mode clears low counter on each of its matches
// - pulse mode inverts toggle when high counter hits either compare
// - initial toggle state sets pulse polarity
// - pwm uses only the high timer; low timer stays independent
// - pwm inverts on high match and on 2^n-1 overflow, which clears
// - pwm raises the high interrupt on the high compare match
// - match-driven inversion happens only while toggle enable is 1
module pit_timer_pair
  import pit_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   toggle_output_pin_o,
  output logic                   low_match_irq_o,
  output logic                   high_match_irq_o,
  output logic                   pair_b_low_irq_o,
  output logic                   pair_b_high_irq_o
);

  // software registers
  logic [7:0]  run_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  clk_reg;
  logic [7:0]  cmp_reg [0:3];
  logic        tog_en_reg;
  logic        tog_src_reg;
  logic [7:0]  rdata_reg;
  // block state
  logic [7:0]  pre_reg;
  logic [7:0]  pre_next;
  logic        output_toggle_ff_reg;
  logic        output_toggle_ff_next;
  logic [1:0]  armed_reg;
  logic [1:0]  armed_next;
  logic [3:0]  irq_reg;
  logic [3:0]  irq_next;

  // per timer and per pair nets
  logic [7:0]  cnt_w [0:3];
  logic [3:0]  inc_w;
  logic [3:0]  clr_w;
  logic [3:0]  match_w;
  logic [3:0]  ovf_w;
  logic [3:0]  cmp_en_w;
  logic [3:0]  wr_cmp;
  logic [1:0]  is16_w;
  logic [1:0]  isppg_w;
  logic [1:0]  ispwm_w;
  logic [1:0]  m16_w;
  logic [1:0]  ppg_lo_w;
  logic [1:0]  pwm_end_w;
  logic [1:0]  inv_w;
  logic [1:0]  irq_lo_w;
  logic [1:0]  irq_hi_w;
  logic [2:0]  taps;
  logic        wr_tffc;
  logic        sw_cmd;
  logic [1:0]  cmd;
  logic [7:0]  tffc_rd;
  logic [7:0]  rd_word;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // address compare shared by the run, mode, clock and toggle-control write and read decodes
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] off);
    addr_is = (a == off);
  endfunction

  // prescaler tap chosen by a two-bit clock source code; 00 means no tap
  function automatic logic tap_sel(input logic [1:0] code, input logic [2:0] t);
    tap_sel = (code == CK_T1)  ? t[0] :
              (code == CK_T16) ? t[1] :
              (code == CK_T256) ? t[2] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescaler: one-cycle enables every 1, 16 and 256 clocks; stopping it clears it
  assign pre_next = run_reg[RUN_PRESC_BIT] ? pre_reg + 8'h01 : PRE_RST;
  assign taps[0]  = run_reg[RUN_PRESC_BIT];
  assign taps[1]  = run_reg[RUN_PRESC_BIT] & (pre_reg[3:0] == PRE_T16_END);
  assign taps[2]  = run_reg[RUN_PRESC_BIT] & (pre_reg == PRE_T256_END);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pre_reg <= PRE_RST;
    else
      pre_reg <= pre_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_tffc = we_i & addr_is(addr_i, ADR_TFFC);
  assign cmd     = wdata_i[TFFC_CMD_LSB +: 2];
  assign sw_cmd  = wr_tffc & (cmd != CMD_KEEP);   // 1,1 leaves the toggle alone

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_wcmp
      assign wr_cmp[i] = we_i & (addr_i[3:2] == PAGE_CMP) & (addr_i[1:0] == 2'(i));
    end
  endgenerate

  // control registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_reg     <= RUN_RST;
      mode_reg    <= MODE_RST;
      clk_reg     <= CLK_RST;
      tog_en_reg  <= TEN_RST;
      tog_src_reg <= TSRC_RST;
    end
    else
    begin
      if (we_i && addr_is(addr_i, ADR_RUN))
        run_reg <= wdata_i;
      if (we_i && addr_is(addr_i, ADR_MODE))
        mode_reg <= wdata_i;
      if (we_i && addr_is(addr_i, ADR_CLK))
        clk_reg <= wdata_i;
      if (wr_tffc)
      begin
        tog_en_reg  <= wdata_i[TFFC_EN_BIT];
        tog_src_reg <= wdata_i[TFFC_SRC_BIT];
      end
    end
  end

  // compare registers are write-only storage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int k = 0; k < 4; k++)
        cmp_reg[k] <= CMP_RST;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
        if (wr_cmp[k])
          cmp_reg[k] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the four up-counters
  generate
    for (i = 0; i < 4; i++)
    begin : g_unit
      pit_counter u_cnt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (run_reg[i]),
        .inc_i    (inc_w[i]),
        .clr_i    (clr_w[i]),
        .cmp_i    (cmp_reg[i]),
        .cmp_en_i (cmp_en_w[i]),
        .count_o  (cnt_w[i]),
        .match_o  (match_w[i]),
        .ovf_o    (ovf_w[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pair sequencing; pair b only knows 8-bit and 16-bit, so its mode
  // is one bit and the pulse and pwm terms stay quiet there
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_pair
      localparam int LO = 2 * p;
      localparam int HI = 2 * p + 1;
      logic [1:0] pm;
      logic [1:0] ck_lo;
      logic [1:0] ck_hi;
      logic [7:0] hi_inc;
      logic [7:0] hi_next;
      logic [7:0] pwm_lim;

      assign pm = (p == 0) ? mode_reg[MODE_PA_LSB +: 2] :
                             {1'b0, mode_reg[MODE_PB_BIT]};
      assign ck_lo = clk_reg[2 * LO +: 2];
      assign ck_hi = clk_reg[2 * HI +: 2];
      assign is16_w[p]  = (pm == PM_16BIT);
      assign isppg_w[p] = (pm == PM_PPG);
      assign ispwm_w[p] = (pm == PM_PWM);

      // low timer always uses its own tap; high is cascaded in 16-bit mode
      assign inc_w[LO] = tap_sel(ck_lo, taps);
      assign inc_w[HI] = is16_w[p] ? ovf_w[LO] :
                         ((pm == PM_8BIT) && (ck_hi == CK_CASC)) ? match_w[LO] :
                         tap_sel(ck_hi, taps);

      // in 16-bit mode, comparators stay off between the low and the high compare write
      assign armed_next[p] = wr_cmp[LO] ? 1'b0 :
                             wr_cmp[HI] ? 1'b1 : armed_reg[p];
      assign cmp_en_w[LO] = !is16_w[p] | armed_reg[p];
      assign cmp_en_w[HI] = !is16_w[p] | armed_reg[p];

      // full 16-bit match: low hits while high is, or is becoming, its compare
      assign hi_inc  = cnt_w[HI] + 8'h01;
      assign hi_next = ovf_w[LO] ? hi_inc : cnt_w[HI];
      assign m16_w[p] = is16_w[p] & match_w[LO] & (hi_next == cmp_reg[HI]);

      // pulse mode: high counter against the low compare as a second edge
      assign ppg_lo_w[p] = isppg_w[p] & run_reg[HI] & inc_w[HI] &
                           (hi_inc == cmp_reg[LO]);

      // pwm period end: the tick that would reach 2^n-1 wraps to zero, so a period is 2^n-1 ticks
      assign pwm_lim = (mode_reg[MODE_PWM_LSB +: 2] == PW_N6) ? PWM_LIM6 :
                       (mode_reg[MODE_PWM_LSB +: 2] == PW_N7) ? PWM_LIM7 : PWM_LIM8;
      assign pwm_end_w[p] = ispwm_w[p] & run_reg[HI] & inc_w[HI] &
                            (hi_inc == pwm_lim);

      // clears: 16-bit only on the full match, pwm high timer only at period end
      assign clr_w[LO] = is16_w[p] ? m16_w[p] : match_w[LO];
      assign clr_w[HI] = is16_w[p]  ? m16_w[p] :
                         ispwm_w[p] ? pwm_end_w[p] : match_w[HI];

      // interrupt events
      assign irq_lo_w[p] = isppg_w[p] ? ppg_lo_w[p] : match_w[LO];
      assign irq_hi_w[p] = is16_w[p] ? m16_w[p] : match_w[HI];

      // inversion events; the source select bit matters only in 8-bit mode
      assign inv_w[p] = is16_w[p]  ? m16_w[p] :
                        isppg_w[p] ? (ppg_lo_w[p] | match_w[HI]) :
                        ispwm_w[p] ? (match_w[HI] | pwm_end_w[p]) :
                        (tog_src_reg ? match_w[HI] : match_w[LO]);
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      armed_reg <= {ARM_RST, ARM_RST};
    else
      armed_reg <= armed_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // output toggle: a software command in the same cycle as a match wins,
  // so the programmed start level is what the pulse train starts from
  assign output_toggle_ff_next =
    sw_cmd ? ((cmd == CMD_CLR) ? 1'b0 :
              (cmd == CMD_SET) ? 1'b1 : ~output_toggle_ff_reg) :
    (inv_w[0] & tog_en_reg) ? ~output_toggle_ff_reg :
    output_toggle_ff_reg;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      output_toggle_ff_reg <= TOG_RST;
    else
      output_toggle_ff_reg <= output_toggle_ff_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt lines are one-cycle pulses one clock after the event
  assign irq_next = {irq_hi_w[1], irq_lo_w[1], irq_hi_w[0], irq_lo_w[0]};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_reg <= 4'h0;
    else
      irq_reg <= irq_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; compare values and the toggle have no read path at all
  assign tffc_rd = {6'h00, tog_en_reg, tog_src_reg};
  assign rd_word = addr_is(addr_i, ADR_RUN)  ? run_reg  :
                   addr_is(addr_i, ADR_MODE) ? mode_reg :
                   addr_is(addr_i, ADR_CLK)  ? clk_reg  :
                   addr_is(addr_i, ADR_TFFC) ? tffc_rd  :
                   (addr_i[3:2] == PAGE_CNT) ? cnt_w[addr_i[1:0]] :
                   RD_RST;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= RD_RST;
    else
      rdata_reg <= re_i ? rd_word : RD_RST;
  end

  assign rdata_o             = rdata_reg;
  assign toggle_output_pin_o = output_toggle_ff_reg;
  assign low_match_irq_o     = irq_reg[0];
  assign high_match_irq_o    = irq_reg[1];
  assign pair_b_low_irq_o    = irq_reg[2];
  assign pair_b_high_irq_o   = irq_reg[3];

  ////////////////////////////////////////////////////////////////////////
  // checks on the toggle commands
  a_cmd_invert:
    assert property (sw_cmd && cmd == CMD_INV |=> toggle_output_pin_o != $past(toggle_output_pin_o))
    else $error("toggle invert command ignored");
  a_cmd_clear:
    assert property (sw_cmd && cmd == CMD_CLR |=> !toggle_output_pin_o)
    else $error("toggle clear command ignored");
  a_cmd_set:
    assert property (sw_cmd && cmd == CMD_SET |=> toggle_output_pin_o)
    else $error("toggle set command ignored");
  a_enable_gate:
    assert property (!tog_en_reg && !sw_cmd |=> $stable(toggle_output_pin_o))
    else $error("toggle moved while inversion disabled");

  // checks on the cascade
  a_cascade_clock:
    assert property (is16_w[0] && !ovf_w[0] && !m16_w[0] && run_reg[1] |=> $stable(cnt_w[1]))
    else $error("16-bit high counter moved without low overflow");
  a_disarm_write:
    assert property (wr_cmp[0] && is16_w[0] |=> !armed_reg[0] ##1 (armed_reg[0] || !match_w[0]))
    else $error("comparator not halted after low compare write");
  a_low_noclear:
    assert property (is16_w[0] && match_w[0] && !m16_w[0]
                     |=> cnt_w[0] == $past(cmp_reg[0]) && low_match_irq_o)
    else $error("16-bit low match cleared counter or lost its irq");
  a_full_match:
    assert property (m16_w[0] |=> cnt_w[0] == 8'h00 && cnt_w[1] == 8'h00 && high_match_irq_o)
    else $error("16-bit match did not clear both counters");
  a_only_full:
    assert property (is16_w[0] && !m16_w[0] && !sw_cmd |=> $stable(toggle_output_pin_o))
    else $error("toggle moved without a 16-bit match");
  a_cascade8_clear:
    assert property (mode_reg[3:2] == PM_8BIT && match_w[0] |=> cnt_w[0] == 8'h00)
    else $error("8-bit low match did not clear the counter");

  // checks on pulse and pwm modes
  a_ppg_invert:
    assert property (isppg_w[0] && tog_en_reg && !sw_cmd && (ppg_lo_w[0] || match_w[1])
                     |=> toggle_output_pin_o == !$past(toggle_output_pin_o))
    else $error("pulse mode edge missing");
  a_ppg_clear:
    assert property (isppg_w[0] && match_w[1] |=> cnt_w[1] == 8'h00 ##1 cnt_w[1] <= cmp_reg[1])
    else $error("pulse mode high counter not cleared");
  a_pwm_end:
    assert property (pwm_end_w[0] |=> cnt_w[1] == 8'h00)
    else $error("pwm period end did not clear counter");
  a_pwm_irq:
    assert property (ispwm_w[0] && match_w[1] && !pwm_end_w[0] |=> high_match_irq_o && cnt_w[1] != 8'h00)
    else $error("pwm compare match lost irq or cleared counter");

endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import pit_pkg::*;
;
  logic              clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              we_i;
  logic              re_i;
  logic [DATA_W-1:0] rdata_o;
  logic              toggle_output_pin_o;
  logic              low_match_irq_o;
  logic              high_match_irq_o;
  logic              pair_b_low_irq_o;
  logic              pair_b_high_irq_o;
  int                n_errors;
  int                check_count;
  int                cycles;
  int                flips;
  int                ones;
  int                n_hi;
  int                g;
  int                per;
  logic [7:0]        d;

  pit_timer_pair pit_timer_pair_i (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .we_i                (we_i),
    .re_i                (re_i),
    .rdata_o             (rdata_o),
    .toggle_output_pin_o (toggle_output_pin_o),
    .low_match_irq_o     (low_match_irq_o),
    .high_match_irq_o    (high_match_irq_o),
    .pair_b_low_irq_o    (pair_b_low_irq_o),
    .pair_b_high_irq_o   (pair_b_high_irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 100 ns clock; the cycle ceiling sits far above the few thousand cycles the tests need
  always #50 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes; ends mid-cycle so the next call waits a full edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask

  // monitor on the falling edge, where registered outputs have settled
  task automatic watch(input int n);
    logic prev;
    flips = 0;
    ones  = 0;
    n_hi  = 0;
    @(negedge clk_i);
    prev = toggle_output_pin_o;
    repeat (n)
    begin
      @(negedge clk_i);
      if (toggle_output_pin_o !== prev)
        flips = flips + 1;
      prev = toggle_output_pin_o;
      if (toggle_output_pin_o === 1'b1)
        ones = ones + 1;
      if (high_match_irq_o === 1'b1)
        n_hi = n_hi + 1;
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0:       pick = low_match_irq_o;
      1:       pick = high_match_irq_o;
      3:       pick = pair_b_low_irq_o;
      default: pick = pair_b_high_irq_o;
    endcase
  endfunction

  // spacing between two pulses; phase-free, so the start latency does not matter
  task automatic gap_of(input int sel, output int n);
    int w;
    n = 0;
    w = 0;
    do
    begin
      @(negedge clk_i);
      w = w + 1;
    end
    while (pick(sel) !== 1'b1 && w < 3000);
    do
    begin
      @(negedge clk_i);
      n = n + 1;
    end
    while (pick(sel) !== 1'b1 && n < 3000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    addr_i      = '0;
    wdata_i     = '0;
    we_i        = 1'b0;
    re_i        = 1'b0;
    n_errors    = 0;
    check_count = 0;
    cycles      = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    // software commands with all timers stopped
    check("pin after reset", toggle_output_pin_o, TOG_RST);
    wr(ADR_TFFC, {4'h0, CMD_SET, 2'b00});
    check("pin after set", toggle_output_pin_o, 1'b1);
    wr(ADR_TFFC, {4'h0, CMD_INV, 2'b00});
    check("pin after invert", toggle_output_pin_o, 1'b0);
    wr(ADR_TFFC, {4'h0, CMD_INV, 2'b00});
    check("pin after second invert", toggle_output_pin_o, 1'b1);
    wr(ADR_TFFC, {4'h0, CMD_KEEP, 2'b00});
    check("pin after keep", toggle_output_pin_o, 1'b1);
    wr(ADR_TFFC, {4'h0, CMD_CLR, 2'b00});
    check("pin after clear", toggle_output_pin_o, 1'b0);
    wr(ADR_TFFC, {4'h0, CMD_SET, 2'b11});
    rd(ADR_TFFC, d);
    check("toggle control readback", d, 8'h03);
    rd(4'hc, d);
    check("unmapped read", d, 8'h00);
    $display("test software toggle done");
    // cascaded 8-bit: high timer counts low matches
    wr(ADR_RUN, 8'h00);
    wr(ADR_MODE, 8'h00);
    wr(ADR_CLK, 8'h01);
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h02);
    wr(ADR_TFFC, 8'h01);
    wr(ADR_RUN, 8'h23);
    watch(60);
    check("flips with inversion off", flips, 0);
    gap_of(0, g);
    check("low period cascaded", g, 3);
    gap_of(1, g);
    check("high period cascaded", g, 6);
    wr(ADR_TFFC, 8'h0e);
    watch(30);
    check("flips on low matches", flips, 10);
    wr(ADR_TFFC, 8'h0f);
    watch(30);
    check("flips on high matches", flips, 5);
    // slower prescaler taps; the gap between two matches is phase-free
    wr(ADR_CLK, 8'h02);
    gap_of(0, g);
    check("low period on 16-clock tap", g, 16'd48);
    wr(ADR_CLK, 8'h03);
    gap_of(0, g);
    check("low period on 256-clock tap", g, 16'd768);
    $display("test cascaded 8-bit done");
    // 16-bit on both pairs; high tap 01 must be ignored by the cascade
    wr(ADR_RUN, 8'h00);
    wr(ADR_MODE, 8'h44);
    wr(ADR_CLK, 8'h55);
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h02);
    wr(4'h7, 8'h01);
    wr(ADR_RUN, 8'h2f);
    gap_of(1, g);
    check("16-bit period pair a", g, 16'd260);
    gap_of(2, g);
    check("16-bit period pair b", g, 16'd258);
    watch(520);
    check("16-bit high events", n_hi, 2);
    check("16-bit toggle flips", flips, 2);
    // rewriting only the low byte must hold off every full match of pair a
    wr(4'h4, 8'h04);
    watch(600);
    check("events while disarmed", n_hi, 0);
    // restart from zero: the free-running count has passed the target and
    // would otherwise need a full 16-bit wrap before the next match
    wr(ADR_RUN, 8'h20);
    wr(4'h5, 8'h01);
    wr(ADR_RUN, 8'h2f);
    gap_of(3, g);
    check("16-bit low match spacing pair b", g, 16'd256);
    gap_of(1, g);
    check("period after rearm", g, 16'd260);
    $display("test 16-bit done");
    // pulse mode, period 5, edges at counts 2 and 5
    wr(ADR_RUN, 8'h00);
    wr(ADR_MODE, 8'h08);
    wr(ADR_CLK, 8'h05);
    wr(4'h4, 8'h02);
    wr(4'h5, 8'h05);
    wr(ADR_TFFC, {4'h0, CMD_SET, 2'b11});
    wr(ADR_RUN, 8'h23);
    gap_of(1, g);
    check("pulse period", g, 5);
    watch(50);
    check("pulse flips", flips, 20);
    check("pulse high events", n_hi, 10);
    check("high time from set start", ones, 20);
    wr(ADR_RUN, 8'h00);
    wr(ADR_TFFC, {4'h0, CMD_CLR, 2'b11});
    wr(ADR_RUN, 8'h23);
    watch(50);
    check("high time from clear start", ones, 30);
    // narrower low compare written just after the low event, as software should
    gap_of(0, g);
    check("pulse low event period", g, 5);
    wr(4'h4, 8'h01);
    watch(50);
    check("high time after narrower rewrite", ones, 40);
    $display("test pulse mode done");
    // modulation for period codes 01, 10 and 11, low timer running on its own
    for (int c = 1; c < 4; c++)
    begin
      per = (1 << (5 + c)) - 1;
      wr(ADR_RUN, 8'h00);
      wr(ADR_MODE, 8'h0c | 8'(c));
      wr(ADR_CLK, 8'h05);
      wr(4'h4, 8'h07);
      wr(4'h5, 8'h2d);
      wr(ADR_TFFC, 8'h0f);
      wr(ADR_RUN, 8'h23);
      gap_of(1, g);
      check("modulation period", g, 16'(per));
      watch(2 * per);
      check("modulation flips", flips, 4);
      gap_of(0, g);
      check("independent low period", g, 7);
    end
    // width change: stop, reload, force the pin high, restart
    wr(ADR_RUN, 8'h20);
    wr(4'h5, 8'h10);
    wr(ADR_TFFC, {4'h0, CMD_SET, 2'b11});
    wr(ADR_RUN, 8'h23);
    watch(255);
    check("high time after width change", ones, 16);
    $display("test modulation done");
    summarize();
  end
endmodule
